// >>> logic/parallel_io_port_bank.sv
// six 8-bit i/o ports with apb registers, pad control and external interrupts
// assumes pad inputs synchronous to pclk; pads resolved outside from oe/out/pullup
`timescale 1ns/10ps
`include "io_bank_regs.svh"

// Behaviour
// RL1: selected analog-capable pin switches onto the converter rail under converter control.
// RL2: standard pins: 00 floating in, 01 pull-up in, 10 open-drain, 11 push-pull.
// RL3: pull-up interrupt pins: 01 gives pull-up input raising external interrupts.
// RL4: floating interrupt pins: 01 gives floating input raising external interrupts.
// RL5: high-sink pins: direction only, floating input or true open-drain output.
// RL6: fixed pull-up pin: pull-up only on flash parts, else standard with floating input.
// RL7: pad behaviour follows direction, option and each pin's own capabilities.
// RL8: software moves pins only along safe transitions to avoid spurious interrupts.
// RL9: wait mode leaves pins and registers alone; external interrupt wakes device.
// RL10: halt mode leaves pins and registers alone; external interrupt wakes device.
// RL11: pin event requests interrupt only in interrupt mode with cpu mask clear; irq (evt_status & evt_mask) ignores cpu_int_masked.
// RL12: three registers per port: data, direction, option; all reset to zero.
// RL13: direction 0 input, 1 output; bit x controls pin x.
// RL14: input reads live pin, write only latch; output drives latch, reads latch.
// RL15: hidden request latch clears when cpu fetches its vector.
// RL16: peripheral alternate function overrides port programming; its output forces drive. On flash parts the fixed pull-up pin (port E pin 2) stays undriven.
// RL17: registers byte-wide read/write; write acts on pins at next clock edge.
module parallel_io_port_bank #(
   parameter bit FLASH_VARIANT = 1'b1,
   parameter logic [47:0] ANALOG_CAPABLE = 48'h0000_0000_00ff
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pads
   input wire logic [5:0][7:0] pad_in,
   output logic [5:0][7:0] pad_out,
   output logic [5:0][7:0] pad_oe,
   output logic [5:0][7:0] pad_pullup,
   // peripheral alternate functions
   input wire logic [5:0][7:0] alt_out_en,
   input wire logic [5:0][7:0] alt_out_val,
   input wire logic [5:0][7:0] alt_open_drain,
   output logic [5:0][7:0] alt_in,
   // converter multiplexer
   input wire logic adc_mux_en,
   input wire logic [5:0] adc_pin_sel,
   output logic [47:0] analog_switch,
   // cpu interrupt side
   input wire logic cpu_int_masked,
   input wire logic [3:0] vector_fetch,
   output logic [3:0] ext_irq,
   output logic wake_req,
   output logic irq
);

   io_bank_pkg::state_t st_reg;
   io_bank_pkg::state_t st_next;
   io_bank_pkg::port_bytes_t pull_int;
   io_bank_pkg::port_bytes_t float_int;
   io_bank_pkg::port_bytes_t true_od;
   io_bank_pkg::port_bytes_t fixed_pu;
   io_bank_pkg::port_bytes_t int_en;
   io_bank_pkg::port_bytes_t drive_val;
   io_bank_pkg::port_bytes_t out_mode;
   io_bank_pkg::port_bytes_t od_mode;
   logic [3:0] vec_event;
   logic [4:0] idx;
   logic mapped;
   logic setup_ph;
   logic access_ph;

   // per-pin event under a sense selection
   function automatic logic [7:0] pin_event(input logic [1:0] sense,
                                            input logic [7:0] cur,
                                            input logic [7:0] prev);
      logic [7:0] ev;
      ev = 8'h00;
      unique case (io_bank_pkg::sense_t'(sense))
         io_bank_pkg::sense_low_level: ev = ~cur;
         io_bank_pkg::sense_rising: ev = cur & ~prev;
         io_bank_pkg::sense_falling: ev = ~cur & prev;
         io_bank_pkg::sense_both: ev = cur ^ prev;
      endcase
      return ev;
   endfunction

   // register index of a port register
   function automatic logic [4:0] port_idx(input int p, input int k);
      return 5'((3 * p) + k);
   endfunction

   // capability maps
   always_comb begin
      pull_int = '0;
      float_int = '0;
      true_od = '0;
      fixed_pu = '0;
      pull_int[0] = `PA_PULL_INT;
      float_int[0] = `PA_FLOAT_INT;
      true_od[0] = `PA_TRUE_OD;
      pull_int[1] = `PB_PULL_INT;
      float_int[1] = `PB_FLOAT_INT;
      fixed_pu[4] = `PE_FIXED_PULLUP;
      pull_int[5] = `PF_PULL_INT;
      float_int[5] = `PF_FLOAT_INT;
   end

   // pad control per pin
   always_comb begin
      for (int p = 0; p < 6; p++) begin
         for (int b = 0; b < 8; b++) begin
            out_mode[p][b] = st_reg.dir[p][b] | alt_out_en[p][b]; // RL13 RL16
            drive_val[p][b] = alt_out_en[p][b] ? alt_out_val[p][b] // RL16
                                               : st_reg.data[p][b]; // RL14
            od_mode[p][b] = true_od[p][b] | (alt_out_en[p][b] ? alt_open_drain[p][b]
                                                             : ~st_reg.opt[p][b]); // RL2 RL5
            int_en[p][b] = ~st_reg.dir[p][b] & st_reg.opt[p][b]
                           & (pull_int[p][b] | float_int[p][b]); // RL3 RL4
            pad_pullup[p][b] = ~out_mode[p][b] & st_reg.opt[p][b] & ~float_int[p][b]
                               & ~true_od[p][b] & ~fixed_pu[p][b]; // RL2 RL3 RL4 RL7
            pad_out[p][b] = od_mode[p][b] ? 1'b0 : drive_val[p][b]; // RL2
            pad_oe[p][b] = out_mode[p][b] & (~od_mode[p][b] | ~drive_val[p][b]); // RL7
            if (fixed_pu[p][b] && FLASH_VARIANT) begin
               pad_pullup[p][b] = 1'b1; // RL6
               pad_oe[p][b] = 1'b0; // RL6
               pad_out[p][b] = 1'b0;
            end
            alt_in[p][b] = st_reg.dir[p][b] ? st_reg.data[p][b] : pad_in[p][b];
         end
      end
   end

   // converter rail switches
   always_comb begin
      for (int i = 0; i < 48; i++) begin
         analog_switch[i] = adc_mux_en & ANALOG_CAPABLE[i]
                            & (adc_pin_sel == 6'(i)); // RL1
      end
   end

   // detect per sense, then or per vector
   always_comb begin
      vec_event[0] = |(pin_event(st_reg.sense[1:0], pad_in[0], st_reg.pin_prev[0])
                       & int_en[0] & `VEC0_PA_PINS); // RL11
      vec_event[1] = |(pin_event(st_reg.sense[3:2], pad_in[5], st_reg.pin_prev[5])
                       & int_en[5] & `VEC1_PF_PINS); // RL11
      vec_event[2] = |(pin_event(st_reg.sense[5:4], pad_in[1], st_reg.pin_prev[1])
                       & int_en[1] & `VEC2_PB_PINS); // RL11
      vec_event[3] = |(pin_event(st_reg.sense[7:6], pad_in[1], st_reg.pin_prev[1])
                       & int_en[1] & `VEC3_PB_PINS); // RL11
   end

   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;
   assign idx = paddr[6:2];
   assign mapped = (paddr[1:0] == 2'h0) && (paddr[7] == 1'b0) && (idx <= `IDX_LAST);

   // next state
   always_comb begin
      st_next = st_reg;
      st_next.pin_prev = pad_in;
      // request latch: set wins over vector fetch clear
      st_next.ext_req = (st_reg.ext_req & ~vector_fetch) | vec_event; // RL15
      st_next.evt_status = st_reg.evt_status | vec_event;
      // read data captured in setup phase
      if (setup_ph) begin
         st_next.rdata = 32'h0000_0000;
         st_next.slverr = ~mapped;
         for (int p = 0; p < 6; p++) begin
            if (idx == port_idx(p, 0)) begin
               for (int b = 0; b < 8; b++) begin
                  st_next.rdata[b] = st_reg.dir[p][b] ? st_reg.data[p][b]
                                                      : pad_in[p][b]; // RL14
               end
            end
            if (idx == port_idx(p, 1)) begin
               st_next.rdata[7:0] = st_reg.dir[p];
            end
            if (idx == port_idx(p, 2)) begin
               st_next.rdata[7:0] = st_reg.opt[p];
            end
         end
         if (idx == `IDX_EVT_STATUS) begin
            st_next.rdata[3:0] = st_reg.evt_status;
         end
         if (idx == `IDX_EVT_MASK) begin
            st_next.rdata[3:0] = st_reg.evt_mask;
         end
         if (idx == `IDX_EXT_SENSE) begin
            st_next.rdata[7:0] = st_reg.sense;
         end
         // refused address reads as zero
         if (!mapped) begin
            st_next.rdata = 32'h0000_0000;
         end
      end
      if (access_ph && mapped) begin
         if (pwrite) begin
            for (int p = 0; p < 6; p++) begin
               if (idx == port_idx(p, 0)) begin
                  st_next.data[p] = pwdata[7:0]; // RL12 RL14 RL17
               end
               if (idx == port_idx(p, 1)) begin
                  st_next.dir[p] = pwdata[7:0]; // RL12 RL17
               end
               if (idx == port_idx(p, 2)) begin
                  st_next.opt[p] = pwdata[7:0]; // RL12 RL17
               end
            end
            if (idx == `IDX_EVT_MASK) begin
               st_next.evt_mask = pwdata[3:0];
            end
            if (idx == `IDX_EXT_SENSE) begin
               st_next.sense = pwdata[7:0];
            end
         end else if (idx == `IDX_EVT_STATUS) begin
            // clear only what was shown; new events stay set
            st_next.evt_status = (st_reg.evt_status & ~st_reg.rdata[3:0]) | vec_event;
         end
      end
   end

   // registers run regardless of wait or halt mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg.data <= {6{`PORT_RESET}}; // RL12
         st_reg.dir <= {6{`PORT_RESET}}; // RL12
         st_reg.opt <= {6{`PORT_RESET}}; // RL12
         st_reg.pin_prev <= '0;
         st_reg.ext_req <= 4'h0;
         st_reg.evt_status <= 4'h0;
         st_reg.evt_mask <= 4'h0;
         st_reg.sense <= `SENSE_RESET;
         st_reg.rdata <= 32'h0000_0000;
         st_reg.slverr <= 1'b0;
      end else begin
         st_reg <= st_next; // RL9 RL10
      end
   end

   assign pready = access_ph;
   assign prdata = st_reg.rdata;
   assign pslverr = access_ph & st_reg.slverr;
   assign ext_irq = st_reg.ext_req & {4{~cpu_int_masked}}; // RL11
   assign wake_req = |st_reg.ext_req; // RL9 RL10
   assign irq = |(st_reg.evt_status & st_reg.evt_mask);

endmodule

// >>> logic/io_bank_regs.svh
// register indices, field masks, reset values for the i/o port bank
// assumes byte address = 4 * index on a 32-bit apb bus
`ifndef IO_BANK_REGS_SVH
`define IO_BANK_REGS_SVH

// per-port register indices: data, direction, options
`define IDX_PORT_A_DATA 5'h00
`define IDX_PORT_A_DIR 5'h01
`define IDX_PORT_A_OPT 5'h02
`define IDX_PORT_B_DATA 5'h03
`define IDX_PORT_B_DIR 5'h04
`define IDX_PORT_B_OPT 5'h05
`define IDX_PORT_C_DATA 5'h06
`define IDX_PORT_C_DIR 5'h07
`define IDX_PORT_C_OPT 5'h08
`define IDX_PORT_D_DATA 5'h09
`define IDX_PORT_D_DIR 5'h0a
`define IDX_PORT_D_OPT 5'h0b
`define IDX_PORT_E_DATA 5'h0c
`define IDX_PORT_E_DIR 5'h0d
`define IDX_PORT_E_OPT 5'h0e
`define IDX_PORT_F_DATA 5'h0f
`define IDX_PORT_F_DIR 5'h10
`define IDX_PORT_F_OPT 5'h11
// event status, event mask, edge sense
`define IDX_EVT_STATUS 5'h12
`define IDX_EVT_MASK 5'h13
`define IDX_EXT_SENSE 5'h14
`define IDX_LAST 5'h14

`define PORT_RESET 8'h00
`define SENSE_RESET 8'h00

// pin capability masks, bit x = pin x
`define PA_TRUE_OD 8'hc0
`define PA_PULL_INT 8'h07
`define PA_FLOAT_INT 8'h08
`define PB_PULL_INT 8'h77
`define PB_FLOAT_INT 8'h88
`define PE_FIXED_PULLUP 8'h04
`define PF_PULL_INT 8'h03
`define PF_FLOAT_INT 8'h04

// external interrupt vector groups
`define VEC0_PA_PINS 8'h0f
`define VEC1_PF_PINS 8'h07
`define VEC2_PB_PINS 8'h0f
`define VEC3_PB_PINS 8'hf0

`endif

// >>> logic/io_bank_pkg.sv
// types for the i/o port bank
// assumes io_bank_regs.svh carries the numbers
package io_bank_pkg;

   typedef logic [5:0][7:0] port_bytes_t;

   // edge sense per vector
   typedef enum logic [1:0] {
      sense_low_level = 2'h0,
      sense_rising = 2'h1,
      sense_falling = 2'h2,
      sense_both = 2'h3
   } sense_t;

   typedef struct packed {
      port_bytes_t data;
      port_bytes_t dir;
      port_bytes_t opt;
      port_bytes_t pin_prev;
      logic [3:0] ext_req;
      logic [3:0] evt_status;
      logic [3:0] evt_mask;
      logic [7:0] sense;
      logic [31:0] rdata;
      logic slverr;
   } state_t;

endpackage

// >>> tb/io_bank_props.sv
// checker on the i/o port bank ports
// assumes bound into every parallel_io_port_bank
`timescale 1ns/10ps
module io_bank_props #(
   parameter bit FLASH_VARIANT = 1'b1,
   parameter logic [47:0] ANALOG_CAPABLE = 48'hff
) (
   // clock, reset, apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pads, peripherals, converter, cpu
   input wire logic [5:0][7:0] pad_out,
   input wire logic [5:0][7:0] pad_oe,
   input wire logic [5:0][7:0] pad_pullup,
   input wire logic [5:0][7:0] alt_out_en,
   input wire logic adc_mux_en,
   input wire logic [5:0] adc_pin_sel,
   input wire logic [47:0] analog_switch,
   input wire logic cpu_int_masked,
   input wire logic [3:0] ext_irq,
   input wire logic wake_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_zero_wait: assert property (pready == (psel && penable)) else $error("pready");
   a_bad_addr: assert property (psel && penable && paddr[1:0] != 2'h0
      |-> pslverr && prdata == 32'h0) else $error("refusal");
   a_masked_quiet: assert property (cpu_int_masked |-> ext_irq == 4'h0) else $error("mask");
   a_wake_on_req: assert property (ext_irq != 4'h0 |-> wake_req) else $error("wake");
   a_drain_only: assert property ((pad_oe[0][7:6] & pad_out[0][7:6]) == 2'h0
      && pad_pullup[0][7:6] == 2'h0) else $error("drain");
   a_fixed_pull: assert property (FLASH_VARIANT && !alt_out_en[4][2]
      |-> pad_pullup[4][2] && !pad_oe[4][2]) else $error("pullup pin");
   a_rail_select: assert property (adc_mux_en && ANALOG_CAPABLE[adc_pin_sel]
      |-> analog_switch == (48'h1 << adc_pin_sel)) else $error("rail");
   a_dir_input: assert property (psel && penable && pwrite && paddr == 8'h1c
      ##1 alt_out_en[2] == 8'h0 |-> ({24'h0, pad_oe[2]} & ~$past(pwdata)) == 32'h0)
      else $error("input drives");
   c_refused: cover property (psel && penable && pslverr);
   c_pending: cover property (ext_irq[0] && !cpu_int_masked);
   c_alt: cover property (alt_out_en != 48'h0);
endmodule

bind parallel_io_port_bank io_bank_props #(.FLASH_VARIANT(FLASH_VARIANT),
   .ANALOG_CAPABLE(ANALOG_CAPABLE)) u_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .pad_out, .pad_oe, .pad_pullup,
   .alt_out_en, .adc_mux_en, .adc_pin_sel, .analog_switch, .cpu_int_masked, .ext_irq,
   .wake_req);

// >>> tb/io_board.sv
// board model: resolves each pin from the bank and a board driver
// assumes pclk from the bench; undriven floating pins wander
`timescale 1ns/10ps
module io_board (
   // clock
   input wire logic pclk,
   // bank side
   input wire logic [5:0][7:0] pad_out,
   input wire logic [5:0][7:0] pad_oe,
   input wire logic [5:0][7:0] pad_pullup,
   // board driver
   input wire logic [5:0][7:0] ext_en,
   input wire logic [5:0][7:0] ext_val,
   output logic [5:0][7:0] pad_in
);
   logic [47:0] wander = 48'h0;
   always @(posedge pclk) wander <= ~wander;
   // released drain pins float or pull up
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
      | (~pad_oe & ~ext_en & (pad_pullup | wander));
endmodule

// >>> tb/test_parallel_io_port_bank.sv
// self-checking bench for the i/o port bank
// assumes design, board model and checker compiled first
`timescale 1ns/10ps
`include "io_bank_regs.svh"
module test_parallel_io_port_bank;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, wake_req, irq;
   logic adc_mux_en, cpu_int_masked;
   logic [7:0] paddr, d, o, l;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [5:0] adc_pin_sel;
   logic [3:0] vector_fetch, ext_irq;
   logic [5:0][7:0] pad_in, pad_out, pad_oe, pad_pullup, alt_in, ext_en, ext_val;
   logic [5:0][7:0] alt_out_en, alt_out_val, alt_open_drain;
   logic [47:0] analog_switch;
   int miscompares, cmp_count;
   parallel_io_port_bank u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .pad_pullup,
      .alt_out_en, .alt_out_val, .alt_open_drain, .alt_in, .adc_mux_en, .adc_pin_sel,
      .analog_switch, .cpu_int_masked, .vector_fetch, .ext_irq, .wake_req, .irq);
   io_board u_board (.pclk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_val, .pad_in);
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [7:0] ra(int p, int r);
      return 8'((3 * p + r) * 4);
   endfunction
   // expected {oe, driven high, pull-up} of one port
   function automatic logic [23:0] exp_pad(int p, logic [7:0] d, logic [7:0] o, logic [7:0] l);
      logic [7:0] tod, fl, fx, oe;
      tod = (p == 0) ? `PA_TRUE_OD : 8'h00;
      fl = (p == 0) ? `PA_FLOAT_INT : (p == 1) ? `PB_FLOAT_INT : (p == 5) ? `PF_FLOAT_INT : 8'h00;
      fx = (p == 4) ? `PE_FIXED_PULLUP : 8'h00;
      oe = d & ((o & ~tod) | ~l) & ~fx;
      return {oe, l & oe, (~d & o & ~(tod | fl) & ~fx) | fx};
   endfunction
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      seed = 32'h0000ab0d;
      {psel, penable, pwrite, adc_mux_en, cpu_int_masked, presetn} = 6'h0;
      {paddr, pwdata, adc_pin_sel, vector_fetch} = '0;
      {alt_out_en, alt_out_val, alt_open_drain, ext_en, ext_val} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 21; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         if (i % 3 != 0 || i > 17) chk(rd, 32'h0);
      end
      apb(1'b0, 8'h54, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(1'b1, 8'h02, 32'h0);
      chk({31'h0, err}, 32'h1);
      for (int p = 0; p < 6; p++) begin
         for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : rnd();
            o = (k < 2) ? 8'hff : rnd();
            l = rnd();
            apb(1'b1, ra(p, 0), {24'h0, l});
            apb(1'b1, ra(p, 2), {24'h0, o});
            apb(1'b1, ra(p, 1), {24'h0, d});
            @(negedge pclk);
            chk({8'h0, pad_oe[p], pad_out[p] & pad_oe[p], pad_pullup[p]}, {8'h0, exp_pad(p, d, o, l)});
            apb(1'b0, ra(p, 1), 32'h0);
            chk(rd, {24'h0, d});
            apb(1'b0, ra(p, 2), 32'h0);
            chk(rd, {24'h0, o});
         end
      end
      ext_en[3] <= 8'hff;
      ext_val[3] <= rnd();
      apb(1'b1, ra(3, 0), 32'h5a);
      apb(1'b1, ra(3, 1), 32'h0f);
      apb(1'b0, ra(3, 0), 32'h0);
      chk(rd, {24'h0, 8'h0a | (ext_val[3] & 8'hf0)});
      alt_out_en[3] <= 8'h80;
      alt_out_val[3] <= 8'h80;
      adc_pin_sel <= 6'(rnd() % 8);
      adc_mux_en <= 1'b1;
      @(negedge pclk);
      chk({pad_oe[3][7], pad_out[3][7], alt_in[3][3:0]}, 32'h3a);
      chk(analog_switch[31:0], 32'h1 << adc_pin_sel);
      ext_en[0] <= 8'hff;
      ext_val[0] <= 8'hff;
      apb(1'b1, ra(1, 2), 32'h0);
      apb(1'b1, ra(5, 2), 32'h0);
      apb(1'b1, ra(0, 1), 32'h0);
      apb(1'b1, ra(0, 2), 32'h01);
      apb(1'b1, 8'h50, 32'h02);
      apb(1'b1, 8'h4c, 32'h01);
      vector_fetch <= 4'hf;
      @(posedge pclk);
      vector_fetch <= 4'h0;
      apb(1'b0, 8'h48, 32'h0);
      ext_val[0] <= 8'hfe;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk({irq, ext_irq[0], wake_req}, 32'h7);
      cpu_int_masked <= 1'b1;
      @(negedge pclk);
      chk({ext_irq, wake_req}, 32'h1);
      @(posedge pclk);
      vector_fetch <= 4'h1;
      @(posedge pclk);
      vector_fetch <= 4'h0;
      @(negedge pclk);
      chk(wake_req, 1'b0);
      apb(1'b0, 8'h48, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 8'h48, 32'h0);
      chk({rd[30:0], irq}, 32'h0);
      report_and_stop();
   end
endmodule
